/* File: src/upcagc_map.svh */
// register offsets, field positions and reset values of the upconverter control block
`ifndef UPCAGC_MAP_SVH
`define UPCAGC_MAP_SVH

// register offsets
`define UPCAGC_OFF_CFG_A      12'h000
`define UPCAGC_OFF_CFG_B      12'h001
`define UPCAGC_OFF_CHIP_KIND  12'h003
`define UPCAGC_OFF_PART_LO    12'h004
`define UPCAGC_OFF_PART_HI    12'h005
`define UPCAGC_OFF_SCRATCH    12'h00a
`define UPCAGC_OFF_IF_REV     12'h00b
`define UPCAGC_OFF_MAKER_LO   12'h00c
`define UPCAGC_OFF_MAKER_HI   12'h00d
`define UPCAGC_OFF_INT_LO     12'h010
`define UPCAGC_OFF_INT_HI     12'h011
`define UPCAGC_OFF_CAL_PRE    12'h012
`define UPCAGC_OFF_FRAC_LO    12'h014
`define UPCAGC_OFF_FRAC_MID   12'h015
`define UPCAGC_OFF_FRAC_HI    12'h016
`define UPCAGC_OFF_FRAC_MIX   12'h017
`define UPCAGC_OFF_SYNTH_CTL  12'h01e
`define UPCAGC_OFF_OSC_CTL    12'h027
`define UPCAGC_OFF_RF_BIAS    12'h100
`define UPCAGC_OFF_LOOP_EN    12'h101
`define UPCAGC_OFF_LOOP_FORCE 12'h102
`define UPCAGC_OFF_DET_SPAN   12'h10c
`define UPCAGC_OFF_SETPOINT   12'h10d
`define UPCAGC_OFF_STATUS     12'h110

// field positions
`define UPCAGC_BIT_SYNTH_SLEEP 2
`define UPCAGC_BIT_OSC_SLEEP   2
`define UPCAGC_BIT_RF_BIAS_OFF 7
`define UPCAGC_BIT_LOOP_EN     0
`define UPCAGC_BIT_LOOP_FORCE  0

// reset values
`define UPCAGC_RST_ZERO   8'h00
`define UPCAGC_RST_INT_LO 8'h80

`endif

/* File: src/upcagc_pkg.sv */
// types shared by the upconverter control block
`default_nettype none
package upcagc_pkg;
  // power sequencing state
  typedef enum logic [1:0] {
    upcagc_pwr_run,
    upcagc_pwr_lowest,
    upcagc_pwr_relock
  } upcagc_pwr_t;
endpackage
`default_nettype wire

/* File: src/upcagc_loop.sv */
// digital model of the if gain loop integrator
`default_nettype none
module upcagc_loop #(
  parameter int GW = 8,
  parameter int SW = 2
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          srst,
  // loop control
  input  wire logic          run,
  input  wire logic [SW-1:0] span,
  input  wire logic [GW-1:0] setpoint,
  // detector reading and gain result
  input  wire logic [GW-1:0] det_level,
  output logic      [GW-1:0] gain_r
);

  logic [GW-1:0] scaled;

  ////////////////////////////////////////////////////////////////////////////
  // detector span scales the reading before comparison
  assign scaled = det_level >> span;

  // step gain toward the setpoint while running, hold otherwise
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gain_r <= '0;
    end else if (run) begin
      if (scaled < setpoint && gain_r != {GW{1'b1}}) begin
        gain_r <= gain_r + 1'b1;
      end else if (scaled > setpoint && gain_r != '0) begin
        gain_r <= gain_r - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_gain_hold: assert property (@(posedge ref_clk) disable iff (srst)
    !run |=> $stable(gain_r)) else $error("gain moved while loop idle");

  chk_gain_rise: assert property (@(posedge ref_clk) disable iff (srst)
    run && scaled < setpoint && gain_r != {GW{1'b1}} |=> gain_r == $past(gain_r) + 1'b1)
    else $error("gain did not rise below setpoint");

  chk_gain_fall: assert property (@(posedge ref_clk) disable iff (srst)
    run && scaled > setpoint && gain_r != '0 |=> gain_r == $past(gain_r) - 1'b1)
    else $error("gain did not fall above setpoint");

endmodule
`default_nettype wire

/* File: src/upcagc_top.sv */
// register bank, power control and if gain loop control of the upconverter
`include "upcagc_map.svh"
`default_nettype none
module upcagc_top #(
  parameter logic [7:0] CHIP_KIND_VAL = 8'h0a, // arbitrary value
  parameter logic [7:0] PART_LO_VAL   = 8'h3c, // arbitrary value
  parameter logic [7:0] PART_HI_VAL   = 8'h5a, // arbitrary value
  parameter logic [7:0] IF_REV_VAL    = 8'h02, // arbitrary value
  parameter logic [7:0] MAKER_LO_VAL  = 8'h7e, // arbitrary value
  parameter logic [7:0] MAKER_HI_VAL  = 8'h6b, // arbitrary value
  parameter int         SPAN_W        = 2
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // standby pin, asynchronous
  input  wire logic        standby_pin,
  // gain control pin, two-way
  input  wire logic [7:0]  gain_control_pin_i,
  output logic      [7:0]  gain_control_pin_o,
  output logic             gain_control_pin_oe,
  // power detector reading, same clock
  input  wire logic [7:0]  det_level,
  // analog section controls
  output logic             mixer_en,
  output logic             driver_en,
  output logic             synth_en,
  output logic             osc_en,
  output logic             rf_bias_en,
  output logic [SPAN_W-1:0] det_span,
  output logic [7:0]       vga_gain,
  output logic             agc_active,
  output logic             synth_relock,
  output logic             lowest_power
);

  // register storage
  logic [7:0] cfg_a_r, cfg_b_r, scratch_r, int_lo_r, int_hi_r, cal_pre_r;
  logic [7:0] frac_lo_r, frac_mid_r, frac_hi_r, frac_mix_r;
  logic [7:0] synth_ctl_r, osc_ctl_r, rf_bias_r, loop_en_r, loop_force_r;
  logic [7:0] det_span_r, setpoint_r;
  // pin synchronisers
  logic       standby_m_r, standby_s_r;
  logic [7:0] ext_m_r, ext_s_r;
  // loop and power control
  logic [7:0] loop_gain;
  logic [7:0] vga_gain_r;
  logic       relock_r;
  logic       all_sleep;
  logic       wr_int_lo;
  upcagc_pkg::upcagc_pwr_t pwr_r, pwr_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for pin inputs
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      standby_m_r <= 1'b0;
      standby_s_r <= 1'b0;
      ext_m_r     <= 8'h00;
      ext_s_r     <= 8'h00;
    end else begin
      standby_m_r <= standby_pin;
      standby_s_r <= standby_m_r;
      ext_m_r     <= gain_control_pin_i;
      ext_s_r     <= ext_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes; read-only and unmapped offsets ignore writes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_a_r      <= `UPCAGC_RST_ZERO;
      cfg_b_r      <= `UPCAGC_RST_ZERO;
      scratch_r    <= `UPCAGC_RST_ZERO;
      int_lo_r     <= `UPCAGC_RST_INT_LO;
      int_hi_r     <= `UPCAGC_RST_ZERO;
      cal_pre_r    <= `UPCAGC_RST_ZERO;
      frac_lo_r    <= `UPCAGC_RST_ZERO;
      frac_mid_r   <= `UPCAGC_RST_ZERO;
      frac_hi_r    <= `UPCAGC_RST_ZERO;
      frac_mix_r   <= `UPCAGC_RST_ZERO;
      synth_ctl_r  <= `UPCAGC_RST_ZERO;
      osc_ctl_r    <= `UPCAGC_RST_ZERO;
      rf_bias_r    <= `UPCAGC_RST_ZERO;
      loop_en_r    <= `UPCAGC_RST_ZERO;
      loop_force_r <= `UPCAGC_RST_ZERO;
      det_span_r   <= `UPCAGC_RST_ZERO;
      setpoint_r   <= `UPCAGC_RST_ZERO;
    end else if (reg_wr) begin
      case (reg_addr)
        `UPCAGC_OFF_CFG_A:      cfg_a_r      <= reg_wdata;
        `UPCAGC_OFF_CFG_B:      cfg_b_r      <= reg_wdata;
        `UPCAGC_OFF_SCRATCH:    scratch_r    <= reg_wdata;
        `UPCAGC_OFF_INT_LO:     int_lo_r     <= reg_wdata;
        `UPCAGC_OFF_INT_HI:     int_hi_r     <= reg_wdata;
        `UPCAGC_OFF_CAL_PRE:    cal_pre_r    <= reg_wdata;
        `UPCAGC_OFF_FRAC_LO:    frac_lo_r    <= reg_wdata;
        `UPCAGC_OFF_FRAC_MID:   frac_mid_r   <= reg_wdata;
        `UPCAGC_OFF_FRAC_HI:    frac_hi_r    <= reg_wdata;
        `UPCAGC_OFF_FRAC_MIX:   frac_mix_r   <= reg_wdata;
        `UPCAGC_OFF_SYNTH_CTL:  synth_ctl_r  <= reg_wdata;
        `UPCAGC_OFF_OSC_CTL:    osc_ctl_r    <= reg_wdata;
        `UPCAGC_OFF_RF_BIAS:    rf_bias_r    <= reg_wdata;
        `UPCAGC_OFF_LOOP_EN:    loop_en_r    <= reg_wdata;
        `UPCAGC_OFF_LOOP_FORCE: loop_force_r <= reg_wdata;
        `UPCAGC_OFF_DET_SPAN:   det_span_r   <= reg_wdata;
        `UPCAGC_OFF_SETPOINT:   setpoint_r   <= reg_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `UPCAGC_OFF_CFG_A:      reg_rdata <= cfg_a_r;
        `UPCAGC_OFF_CFG_B:      reg_rdata <= cfg_b_r;
        `UPCAGC_OFF_CHIP_KIND:  reg_rdata <= CHIP_KIND_VAL;
        `UPCAGC_OFF_PART_LO:    reg_rdata <= PART_LO_VAL;
        `UPCAGC_OFF_PART_HI:    reg_rdata <= PART_HI_VAL;
        `UPCAGC_OFF_SCRATCH:    reg_rdata <= scratch_r;
        `UPCAGC_OFF_IF_REV:     reg_rdata <= IF_REV_VAL;
        `UPCAGC_OFF_MAKER_LO:   reg_rdata <= MAKER_LO_VAL;
        `UPCAGC_OFF_MAKER_HI:   reg_rdata <= MAKER_HI_VAL;
        `UPCAGC_OFF_INT_LO:     reg_rdata <= int_lo_r;
        `UPCAGC_OFF_INT_HI:     reg_rdata <= int_hi_r;
        `UPCAGC_OFF_CAL_PRE:    reg_rdata <= cal_pre_r;
        `UPCAGC_OFF_FRAC_LO:    reg_rdata <= frac_lo_r;
        `UPCAGC_OFF_FRAC_MID:   reg_rdata <= frac_mid_r;
        `UPCAGC_OFF_FRAC_HI:    reg_rdata <= frac_hi_r;
        `UPCAGC_OFF_FRAC_MIX:   reg_rdata <= frac_mix_r;
        `UPCAGC_OFF_SYNTH_CTL:  reg_rdata <= synth_ctl_r;
        `UPCAGC_OFF_OSC_CTL:    reg_rdata <= osc_ctl_r;
        `UPCAGC_OFF_RF_BIAS:    reg_rdata <= rf_bias_r;
        `UPCAGC_OFF_LOOP_EN:    reg_rdata <= loop_en_r;
        `UPCAGC_OFF_LOOP_FORCE: reg_rdata <= loop_force_r;
        `UPCAGC_OFF_DET_SPAN:   reg_rdata <= det_span_r;
        `UPCAGC_OFF_SETPOINT:   reg_rdata <= setpoint_r;
        `UPCAGC_OFF_STATUS:     reg_rdata <= {3'b000, standby_s_r, relock_r,
                                              lowest_power, pwr_r == upcagc_pkg::upcagc_pwr_relock,
                                              agc_active};
        default:                reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gain loop runs when forced, or when armed and in power-down mode
  assign agc_active = loop_force_r[`UPCAGC_BIT_LOOP_FORCE]
                    | (loop_en_r[`UPCAGC_BIT_LOOP_EN] & standby_s_r);
  assign det_span   = det_span_r[SPAN_W-1:0];

  upcagc_loop #(
    .GW (8),
    .SW (SPAN_W)
  ) u_loop (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .run       (agc_active),
    .span      (det_span),
    .setpoint  (setpoint_r),
    .det_level (det_level),
    .gain_r    (loop_gain)
  );

  // pin carries the loop voltage when active, else it is the external control
  assign gain_control_pin_oe = agc_active;
  assign gain_control_pin_o  = loop_gain;

  // gain actually applied to the if amplifier
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      vga_gain_r <= 8'h00;
    end else begin
      vga_gain_r <= agc_active ? loop_gain : ext_s_r;
    end
  end
  assign vga_gain = vga_gain_r;

  ////////////////////////////////////////////////////////////////////////////
  // standby mutes mixer and driver only; sleep bits gate bias
  assign mixer_en   = ~standby_s_r;
  assign driver_en  = ~standby_s_r;
  assign synth_en   = ~synth_ctl_r[`UPCAGC_BIT_SYNTH_SLEEP];
  assign osc_en     = ~osc_ctl_r[`UPCAGC_BIT_OSC_SLEEP];
  assign rf_bias_en = ~rf_bias_r[`UPCAGC_BIT_RF_BIAS_OFF];

  // lowest power needs all three bias sleep bits
  assign all_sleep    = ~synth_en & ~osc_en & ~rf_bias_en;
  assign lowest_power = (pwr_r == upcagc_pkg::upcagc_pwr_lowest);
  assign wr_int_lo    = reg_wr && (reg_addr == `UPCAGC_OFF_INT_LO);

  ////////////////////////////////////////////////////////////////////////////
  // power sequencing: after lowest power, the return to run waits for a relock write
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      upcagc_pkg::upcagc_pwr_run: begin
        if (all_sleep) begin
          pwr_nxt = upcagc_pkg::upcagc_pwr_lowest;
        end
      end
      upcagc_pkg::upcagc_pwr_lowest: begin
        if (!all_sleep) begin
          pwr_nxt = upcagc_pkg::upcagc_pwr_relock;
        end
      end
      upcagc_pkg::upcagc_pwr_relock: begin
        if (all_sleep) begin
          pwr_nxt = upcagc_pkg::upcagc_pwr_lowest;
        end else if (wr_int_lo) begin
          pwr_nxt = upcagc_pkg::upcagc_pwr_run;
        end
      end
      default: pwr_nxt = upcagc_pkg::upcagc_pwr_run;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pwr_r <= upcagc_pkg::upcagc_pwr_run;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // one-cycle relock start on every integer divide low write
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      relock_r <= 1'b0;
    end else begin
      relock_r <= wr_int_lo;
    end
  end
  assign synth_relock = relock_r;

  ////////////////////////////////////////////////////////////////////////////
  chk_arm_standby: assert property (@(posedge ref_clk) disable iff (srst)
    loop_en_r[`UPCAGC_BIT_LOOP_EN] && standby_s_r |-> gain_control_pin_oe)
    else $error("armed loop idle in power-down");

  chk_arm_idle: assert property (@(posedge ref_clk) disable iff (srst)
    !loop_force_r[`UPCAGC_BIT_LOOP_FORCE] && !standby_s_r |-> !agc_active)
    else $error("loop ran outside power-down without force");

  chk_force_run: assert property (@(posedge ref_clk) disable iff (srst)
    reg_wr && reg_addr == `UPCAGC_OFF_LOOP_FORCE && reg_wdata[`UPCAGC_BIT_LOOP_FORCE]
    |=> agc_active) else $error("force-on did not start loop");

  chk_span_write: assert property (@(posedge ref_clk) disable iff (srst)
    reg_wr && reg_addr == `UPCAGC_OFF_DET_SPAN |=> det_span == $past(reg_wdata[SPAN_W-1:0]))
    else $error("detector span not taken");

  // synchronous reset lands one edge late, so a reset cycle never starts an attempt
  chk_pin_ext: assert property (@(posedge ref_clk) disable iff (srst)
    !srst && !agc_active |=> vga_gain == $past(ext_s_r))
    else $error("external gain not applied");

  chk_pin_loop: assert property (@(posedge ref_clk) disable iff (srst)
    !srst && agc_active |=> vga_gain == $past(loop_gain)) else $error("loop gain not applied");

  chk_standby_mute: assert property (@(posedge ref_clk) disable iff (srst)
    standby_pin [*3] |=> !mixer_en && !driver_en) else $error("standby did not mute");

  chk_synth_kept: assert property (@(posedge ref_clk) disable iff (srst)
    standby_s_r && !synth_ctl_r[`UPCAGC_BIT_SYNTH_SLEEP] |-> synth_en && osc_en == !osc_ctl_r[2])
    else $error("standby stopped synthesizer");

  chk_lowest_entry: assert property (@(posedge ref_clk) disable iff (srst)
    all_sleep |=> lowest_power) else $error("lowest power not entered");

  chk_relock_pulse: assert property (@(posedge ref_clk) disable iff (srst)
    pwr_r == upcagc_pkg::upcagc_pwr_relock && wr_int_lo && !all_sleep
    |=> synth_relock && pwr_r == upcagc_pkg::upcagc_pwr_run)
    else $error("relock write did not restart synthesizer");

endmodule
`default_nettype wire

/* File: dv/upcagc_host_model.sv */
// host controller model driving the register port and the standby pin
`default_nettype none
module upcagc_host_model (
  // clock
  input  wire logic        ref_clk,
  // register port
  output logic      [11:0] reg_addr,
  output logic      [7:0]  reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [7:0]  reg_rdata,
  // standby pin
  output logic             standby_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle port at time zero
  initial begin
    reg_addr    = 12'h000;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    standby_pin = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one write cycle; address and data are scrambled once the strobe drops
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  // one read cycle; data taken in the cycle after the strobe only
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask

  // standby level changes just after an edge
  task automatic set_standby(input logic v);
    @(posedge ref_clk);
    standby_pin <= v;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // lowest power: all three bias sleep bits set
  task automatic enter_lowest();
    wr(12'h01e, 8'h04);
    wr(12'h027, 8'h04);
    wr(12'h100, 8'h80);
  endtask

  // back to normal bias, then restart synthesizer locking
  task automatic leave_lowest();
    wr(12'h01e, 8'h00);
    wr(12'h027, 8'h00);
    wr(12'h100, 8'h00);
    wr(12'h010, 8'h80);
  endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the upconverter control block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // identity values handed to the design, arbitrary
  localparam logic [7:0] KIND = 8'h1c;
  localparam logic [7:0] P_LO = 8'h2d;
  localparam logic [7:0] P_HI = 8'h3e;
  localparam logic [7:0] REV  = 8'h4f;
  localparam logic [7:0] M_LO = 8'h61;
  localparam logic [7:0] M_HI = 8'h72;
  // clock, reset and analog side stimulus
  logic        ref_clk   = 1'b0;
  logic        srst      = 1'b1;
  logic [7:0]  pin_in    = 8'h00;
  logic [7:0]  det_level = 8'h00;
  // host to design wiring
  wire  [11:0] reg_addr;
  wire  [7:0]  reg_wdata;
  wire         reg_wr;
  wire         reg_rd;
  wire         standby_pin;
  // design outputs
  logic [7:0]  reg_rdata;
  logic [7:0]  gc_o;
  logic [7:0]  vga_gain;
  logic [1:0]  det_span;
  logic        gc_oe, mixer_en, driver_en, synth_en, osc_en, rf_bias_en;
  logic        agc_active, synth_relock, lowest_power;
  // counters and reference register contents
  int          err_total = 0;
  int          tests_run = 0;
  int          exp_reg [int];
  int          ro_q [$] = '{'h003, 'h004, 'h005, 'h00b, 'h00c, 'h00d};
  int          spans [4] = '{3, 1, 0, 1};

  always #10 ref_clk = ~ref_clk;

  //////////////////////////////////////////////////////////////////////////////
  upcagc_host_model upcagc_host_model_i (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .standby_pin(standby_pin));

  upcagc_top #(.CHIP_KIND_VAL(KIND), .PART_LO_VAL(P_LO), .PART_HI_VAL(P_HI),
    .IF_REV_VAL(REV), .MAKER_LO_VAL(M_LO), .MAKER_HI_VAL(M_HI), .SPAN_W(2)) upcagc_top_i (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .standby_pin(standby_pin),
    .gain_control_pin_i(pin_in), .gain_control_pin_o(gc_o), .gain_control_pin_oe(gc_oe),
    .det_level(det_level), .mixer_en(mixer_en), .driver_en(driver_en),
    .synth_en(synth_en), .osc_en(osc_en), .rf_bias_en(rf_bias_en), .det_span(det_span),
    .vga_gain(vga_gain), .agc_active(agc_active), .synth_relock(synth_relock),
    .lowest_power(lowest_power));

  //////////////////////////////////////////////////////////////////////////////
  // compare one value and count it
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // register map after reset
  task automatic init_model();
    exp_reg = '{'h000:0, 'h001:0, 'h003:KIND, 'h004:P_LO, 'h005:P_HI, 'h00a:0, 'h00b:REV,
      'h00c:M_LO, 'h00d:M_HI, 'h010:'h80, 'h011:0, 'h012:0, 'h014:0, 'h015:0, 'h016:0,
      'h017:0};
  endtask

  // read one place and compare with the reference; unmapped reads give zero
  task automatic rchk(input int a);
    logic [7:0] d;
    upcagc_host_model_i.rd(a[11:0], d);
    check(d, exp_reg.exists(a) ? 8'(exp_reg[a]) : 8'h00, "read");
  endtask

  // loop direction from detector level, span and setpoint
  function automatic int step_dir(int det, int span, int sp);
    int lvl;
    lvl = det >> span;
    return (lvl < sp) ? 1 : ((lvl > sp) ? -1 : 0);
  endfunction

  // verdict and end of run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    int v;
    int g;
    logic [7:0] d8;
    void'($urandom(32'h7ecb));
    init_model();
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    // reset values, then random writes including read-only and unmapped places
    foreach (exp_reg[a]) rchk(a);
    rchk('h020);
    foreach (exp_reg[a]) begin
      v = $urandom_range(255);
      upcagc_host_model_i.wr(a[11:0], v[7:0]);
      if (!(a inside {ro_q})) exp_reg[a] = v;
    end
    upcagc_host_model_i.wr(12'h020, 8'hff);
    foreach (exp_reg[a]) rchk(a);
    rchk('h020);
    // armed only: loop idle while standby is low, pin is an input
    v = $urandom_range(255);
    @(posedge ref_clk);
    pin_in <= v[7:0];
    upcagc_host_model_i.wr(12'h101, 8'h01);
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    check(8'(agc_active), 8'h00, "armed idle");
    check(8'(gc_oe), 8'h00, "pin released");
    check(vga_gain, v[7:0], "pin gain");
    // standby: loop runs, mixer and driver off, synthesizer kept
    // setpoint and detector both zero, so the loop holds its reset gain of zero
    upcagc_host_model_i.set_standby(1'b1);
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    check(8'(agc_active), 8'h01, "armed standby");
    check(8'(gc_oe), 8'h01, "pin driven");
    check(gc_o, 8'h00, "pin drive");
    check(vga_gain, 8'h00, "standby gain");
    check({4'h0, mixer_en, driver_en, synth_en, osc_en}, 8'h03, "standby");
    // force on without standby; detector span and setpoint steer the gain
    upcagc_host_model_i.set_standby(1'b0);
    upcagc_host_model_i.wr(12'h101, 8'h00);
    upcagc_host_model_i.wr(12'h102, 8'h01);
    upcagc_host_model_i.wr(12'h10d, 8'h40);
    det_level <= 8'h80;
    g = 0;
    foreach (spans[k]) begin
      upcagc_host_model_i.wr(12'h10c, 8'(spans[k]));
      repeat (300) @(posedge ref_clk);
      @(negedge ref_clk);
      v = step_dir('h80, spans[k], 'h40);
      if (v > 0) g = 255;
      else if (v < 0) g = 0;
      check(8'(agc_active), 8'h01, "forced");
      check(8'(det_span), 8'(spans[k]), "span");
      check(vga_gain, g[7:0], "loop gain");
      check(gc_o, g[7:0], "loop pin");
    end
    // loop off again: pin returns to an input
    upcagc_host_model_i.wr(12'h102, 8'h00);
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    check(8'(gc_oe), 8'h00, "pin released");
    check(vga_gain, pin_in, "pin gain");
    // two sleep bits are not yet lowest power; all three are, one cycle after the last write
    upcagc_host_model_i.wr(12'h01e, 8'h04);
    upcagc_host_model_i.wr(12'h027, 8'h04);
    repeat (2) @(negedge ref_clk);
    check(8'(lowest_power), 8'h00, "partial sleep");
    upcagc_host_model_i.enter_lowest();
    repeat (2) @(negedge ref_clk);
    check({4'h0, lowest_power, synth_en, osc_en, rf_bias_en}, 8'h08, "lowest");
    // status: only the lowest power bit is up
    upcagc_host_model_i.rd(12'h110, d8);
    check(d8, 8'h04, "status lowest");
    upcagc_host_model_i.leave_lowest();
    @(negedge ref_clk);
    check(8'(synth_relock), 8'h01, "relock pulse");
    @(negedge ref_clk);
    check(8'(synth_relock), 8'h00, "relock end");
    check({4'h0, lowest_power, synth_en, osc_en, rf_bias_en}, 8'h07, "normal bias");
    // reset in mid-run restores every register in the reference map
    @(posedge ref_clk);
    srst <= 1'b1;
    @(posedge ref_clk);
    srst <= 1'b0;
    init_model();
    foreach (exp_reg[a]) rchk(a);
    report_and_stop();
  end
endmodule
`default_nettype wire
